// ### core/fpa_regs.svh
`ifndef FPA_REGS_SVH
`define FPA_REGS_SVH
// Overview of operation
// - alu ops treat data as plain 16-bit patterns
// - overflow set when result msb differs from what operand signs predict
// - positive plus positive giving negative overflows; mixed-sign add never does
// - carry is unsigned, taken from bit 16 of the 17-bit sum (the carry out of bit 15)
// - zero and negative judge the 16-bit result as signed; negative is msb
// - multiplier inputs read signed/unsigned/mixed/round as selected; array is bits
// - product loaded into mac result set is sign-extended over 40 bits
// - product always shifted left one bit before the mac result set
// - fractional format is one sign bit and fifteen fraction bits
// - signed data is two's complement only, never signed-magnitude
// - logical shifts fill zeros; arithmetic shifts keep the sign
// - exponent detection treats its input as two's complement
// - alu flags captured into status register at end of the same cycle

// ==========================================
// register map (axi4-lite word indices, address bits 5:2)
`define FPA_ADDR_XOP      4'h0
`define FPA_ADDR_YOP      4'h1
`define FPA_ADDR_CTRL     4'h2
`define FPA_ADDR_ALU_RES  4'h3
`define FPA_ADDR_STAT     4'h4
`define FPA_ADDR_MAC_LO   4'h5
`define FPA_ADDR_MAC_HI   4'h6
`define FPA_ADDR_SHF_RES  4'h7
`define FPA_ADDR_IRQ_STAT 4'h8
`define FPA_ADDR_IRQ_MASK 4'h9
// ==========================================
// control word fields
`define FPA_CTRL_ALU_LSB  0
`define FPA_CTRL_MUL_LSB  4
`define FPA_CTRL_SHF_LSB  6
`define FPA_CTRL_AMT_LSB  8
`define FPA_CTRL_AMT_W    4
// ==========================================
// status bits
`define FPA_ST_ZERO       0
`define FPA_ST_NEG        1
`define FPA_ST_CARRY      2
`define FPA_ST_OVF        3
`define FPA_ST_W          4
`define FPA_MAC_HI_W      8
`define FPA_ROUND_BIT     32'h0000_8000
`define FPA_RESP_OKAY     2'b00
`define FPA_RESP_SLVERR   2'b10
`endif

// ### core/fpa_pkg.sv
package fpa_pkg;
  typedef enum logic [3:0] {
    FPA_ALU_ADD, FPA_ALU_ADDC, FPA_ALU_SUB, FPA_ALU_SUBB, FPA_ALU_AND,
    FPA_ALU_OR, FPA_ALU_XOR, FPA_ALU_NOTX, FPA_ALU_PASSX, FPA_ALU_NEGX
  } fpa_alu_op_t;
  typedef enum logic [1:0] {FPA_MUL_SS, FPA_MUL_UU, FPA_MUL_SU, FPA_MUL_RND} fpa_mul_t;
  typedef enum logic [1:0] {FPA_SHF_LSL, FPA_SHF_LSR, FPA_SHF_ASR, FPA_SHF_EXP} fpa_shf_t;
  typedef struct packed {
    logic ovf;
    logic carry;
    logic neg;
    logic zero;
  } fpa_flags_t;
  typedef enum {FPA_W_IDLE, FPA_W_RESP} fpa_wstate_t;
endpackage

// ### core/fpa_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "fpa_regs.svh"
module fpa_core (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  // axi4-lite write
  input  wire logic [5:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  // axi4-lite read
  input  wire logic [5:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // interrupt
  output logic             IRQ_O
);
  // ==========================================
  // registers
  logic [15:0]             x_reg;
  logic [15:0]             y_reg;
  logic [11:0]             ctrl_reg;
  logic [15:0]             alu_res_reg;
  fpa_pkg::fpa_flags_t     stat_reg;
  logic [39:0]             mac_reg;
  logic [15:0]             shf_res_reg;
  logic [3:0]              irq_stat_reg;
  logic [3:0]              irq_mask_reg;
  logic                    go_reg;
  logic                    aw_held_reg;
  logic                    w_held_reg;
  logic [3:0]              aw_idx_reg;
  logic                    aw_ok_reg;
  logic [31:0]             wdata_reg;
  logic [3:0]              wstrb_reg;
  fpa_pkg::fpa_wstate_t    wstate_reg;

  // ==========================================
  // alu datapath
  fpa_pkg::fpa_alu_op_t    alu_op;
  logic [16:0]             alu_sum;
  logic [15:0]             alu_r;
  fpa_pkg::fpa_flags_t     alu_fl;
  logic                    cin;
  assign alu_op = fpa_pkg::fpa_alu_op_t'(ctrl_reg[`FPA_CTRL_ALU_LSB +: 4]);
  assign cin    = stat_reg.carry;

  always_comb begin
    alu_sum = 17'h0_0000;
    alu_r   = 16'h0000;
    alu_fl  = '0;
    case (alu_op)
      fpa_pkg::FPA_ALU_ADD:  alu_sum = {1'b0, x_reg} + {1'b0, y_reg};
      fpa_pkg::FPA_ALU_ADDC: alu_sum = {1'b0, x_reg} + {1'b0, y_reg} + {16'h0000, cin};
      fpa_pkg::FPA_ALU_SUB:  alu_sum = {1'b0, x_reg} + {1'b0, ~y_reg} + 17'h0_0001;
      fpa_pkg::FPA_ALU_SUBB: alu_sum = {1'b0, x_reg} + {1'b0, ~y_reg} + {16'h0000, cin};
      fpa_pkg::FPA_ALU_AND:  alu_sum = {1'b0, x_reg & y_reg};
      fpa_pkg::FPA_ALU_OR:   alu_sum = {1'b0, x_reg | y_reg};
      fpa_pkg::FPA_ALU_XOR:  alu_sum = {1'b0, x_reg ^ y_reg};
      fpa_pkg::FPA_ALU_NOTX: alu_sum = {1'b0, ~x_reg};
      fpa_pkg::FPA_ALU_PASSX: alu_sum = {1'b0, x_reg};
      fpa_pkg::FPA_ALU_NEGX: alu_sum = {1'b0, ~x_reg} + 17'h0_0001;
      default:               alu_sum = 17'h0_0000;
    endcase
    alu_r        = alu_sum[15:0];
    alu_fl.zero  = (alu_r == 16'h0000);
    alu_fl.neg   = alu_r[15];
    alu_fl.carry = alu_sum[16];
    case (alu_op)
      fpa_pkg::FPA_ALU_ADD, fpa_pkg::FPA_ALU_ADDC:
        // same signs in, other sign out
        alu_fl.ovf = (x_reg[15] == y_reg[15]) && (alu_r[15] != x_reg[15]);
      fpa_pkg::FPA_ALU_SUB, fpa_pkg::FPA_ALU_SUBB:
        alu_fl.ovf = (x_reg[15] != y_reg[15]) && (alu_r[15] != x_reg[15]);
      fpa_pkg::FPA_ALU_NEGX:
        alu_fl.ovf = x_reg[15] && alu_r[15];
      default:
        alu_fl.ovf = 1'b0;
    endcase
  end

  // ==========================================
  // multiplier
  fpa_pkg::fpa_mul_t       mul_mode;
  logic signed [16:0]      mx;
  logic signed [16:0]      my;
  logic signed [33:0]      prod_full;
  logic [31:0]             prod;
  logic [31:0]             prod_sh;
  assign mul_mode = fpa_pkg::fpa_mul_t'(ctrl_reg[`FPA_CTRL_MUL_LSB +: 2]);

  always_comb begin
    // 17-bit extension picks the reading of each input
    case (mul_mode)
      fpa_pkg::FPA_MUL_UU: begin
        mx = {1'b0, x_reg};
        my = {1'b0, y_reg};
      end
      fpa_pkg::FPA_MUL_SU: begin
        mx = {x_reg[15], x_reg};
        my = {1'b0, y_reg};
      end
      default: begin
        mx = {x_reg[15], x_reg};
        my = {y_reg[15], y_reg};
      end
    endcase
    prod_full = mx * my;
    prod      = prod_full[31:0];
    prod_sh   = {prod[30:0], 1'b0}; // 2.30 to 1.31
    if (mul_mode == fpa_pkg::FPA_MUL_RND) begin
      prod_sh = prod_sh + `FPA_ROUND_BIT;
    end
  end

  // ==========================================
  // shifter
  fpa_pkg::fpa_shf_t       shf_mode;
  logic [3:0]              amt;
  logic [15:0]             shf_r;
  logic                    exp_found;
  always_comb begin
    shf_mode  = fpa_pkg::fpa_shf_t'(ctrl_reg[`FPA_CTRL_SHF_LSB +: 2]);
    amt       = ctrl_reg[`FPA_CTRL_AMT_LSB +: `FPA_CTRL_AMT_W];
    shf_r     = 16'h0000;
    exp_found = 1'b0;
    case (shf_mode)
      fpa_pkg::FPA_SHF_LSL: shf_r = x_reg << amt;
      fpa_pkg::FPA_SHF_LSR: shf_r = x_reg >> amt;
      fpa_pkg::FPA_SHF_ASR: shf_r = 16'($signed(x_reg) >>> amt);
      fpa_pkg::FPA_SHF_EXP: begin
        // first bit off the sign ends the count; a zero count must not reopen it
        for (int i = 14; i >= 0; i--) begin
          if (!exp_found && x_reg[i] != x_reg[15]) begin
            shf_r     = 16'(14 - i);
            exp_found = 1'b1;
          end
        end
        if (!exp_found) begin
          shf_r = 16'h000f;
        end
      end
      default: shf_r = 16'h0000;
    endcase
  end

  // ==========================================
  // axi4-lite write path
  logic                    wr_fire;
  logic                    aw_take;
  logic                    w_take;
  assign aw_take = S_AXI_AWVALID_I && !aw_held_reg && wstate_reg == fpa_pkg::FPA_W_IDLE;
  assign w_take  = S_AXI_WVALID_I && !w_held_reg && wstate_reg == fpa_pkg::FPA_W_IDLE;
  assign wr_fire = aw_held_reg && w_held_reg && wstate_reg == fpa_pkg::FPA_W_IDLE;

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      aw_idx_reg      <= 4'h0;
      aw_ok_reg       <= 1'b0;
      wdata_reg       <= 32'h0000_0000;
      wstrb_reg       <= 4'h0;
      wstate_reg      <= fpa_pkg::FPA_W_IDLE;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= `FPA_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= S_AXI_AWADDR_I[5:2];
        aw_ok_reg   <= S_AXI_AWADDR_I[5:2] <= `FPA_ADDR_IRQ_MASK;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= S_AXI_WDATA_I;
        wstrb_reg  <= S_AXI_WSTRB_I;
      end
      if (wr_fire) begin
        aw_held_reg    <= 1'b0;
        w_held_reg     <= 1'b0;
        wstate_reg     <= fpa_pkg::FPA_W_RESP;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= aw_ok_reg ? `FPA_RESP_OKAY : `FPA_RESP_SLVERR;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
        wstate_reg     <= fpa_pkg::FPA_W_IDLE;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
    end else begin
      // one-cycle pulse a clock after the take; held flags block a second take
      S_AXI_AWREADY_O <= aw_take;
      S_AXI_WREADY_O  <= w_take;
    end
  end

  // ==========================================
  // operand and control registers; a control write runs one operation
  logic                    wr_ok;
  assign wr_ok = wr_fire && aw_ok_reg;
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      x_reg        <= 16'h0000;
      y_reg        <= 16'h0000;
      ctrl_reg     <= 12'h000;
      irq_mask_reg <= 4'h0;
      go_reg       <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (wr_ok && wstrb_reg[0]) begin
        case (aw_idx_reg)
          `FPA_ADDR_XOP:      x_reg[7:0]   <= wdata_reg[7:0];
          `FPA_ADDR_YOP:      y_reg[7:0]   <= wdata_reg[7:0];
          `FPA_ADDR_CTRL:     ctrl_reg[7:0] <= wdata_reg[7:0];
          `FPA_ADDR_IRQ_MASK: irq_mask_reg <= wdata_reg[3:0];
          default: ;
        endcase
      end
      if (wr_ok && wstrb_reg[1]) begin
        case (aw_idx_reg)
          `FPA_ADDR_XOP:  x_reg[15:8]    <= wdata_reg[15:8];
          `FPA_ADDR_YOP:  y_reg[15:8]    <= wdata_reg[15:8];
          `FPA_ADDR_CTRL: ctrl_reg[11:8] <= wdata_reg[11:8];
          default: ;
        endcase
      end
      if (wr_ok && aw_idx_reg == `FPA_ADDR_CTRL) begin
        go_reg <= 1'b1;
      end
    end
  end

  // ==========================================
  // results and flags, captured in the execute cycle
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      alu_res_reg <= 16'h0000;
      stat_reg    <= '0;
      mac_reg     <= 40'h00_0000_0000;
      shf_res_reg <= 16'h0000;
    end else if (go_reg) begin
      alu_res_reg <= alu_r;
      stat_reg    <= alu_fl;
      mac_reg     <= {{`FPA_MAC_HI_W{prod_sh[31]}}, prod_sh};
      shf_res_reg <= shf_r;
    end
  end

  // ==========================================
  // sticky flag events, set wins over write-one-clear
  logic [3:0]              irq_set;
  logic [3:0]              irq_clr;
  assign irq_set = go_reg ? alu_fl : 4'h0;
  assign irq_clr = (wr_ok && wstrb_reg[0] && aw_idx_reg == `FPA_ADDR_IRQ_STAT)
                   ? wdata_reg[3:0] : 4'h0;
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      irq_stat_reg <= 4'h0;
      IRQ_O        <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      IRQ_O        <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end
  end

  // ==========================================
  // axi4-lite read path
  logic [31:0]             rd_mux;
  always_comb begin
    case (S_AXI_ARADDR_I[5:2])
      `FPA_ADDR_XOP:      rd_mux = {16'h0000, x_reg};
      `FPA_ADDR_YOP:      rd_mux = {16'h0000, y_reg};
      `FPA_ADDR_CTRL:     rd_mux = {20'h0_0000, ctrl_reg};
      `FPA_ADDR_ALU_RES:  rd_mux = {16'h0000, alu_res_reg};
      `FPA_ADDR_STAT:     rd_mux = {28'h000_0000, stat_reg};
      `FPA_ADDR_MAC_LO:   rd_mux = mac_reg[31:0];
      `FPA_ADDR_MAC_HI:   rd_mux = {24'h00_0000, mac_reg[39:32]};
      `FPA_ADDR_SHF_RES:  rd_mux = {16'h0000, shf_res_reg};
      `FPA_ADDR_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat_reg};
      `FPA_ADDR_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask_reg};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0000_0000;
      S_AXI_RRESP_O   <= `FPA_RESP_OKAY;
    end else begin
      S_AXI_ARREADY_O <= 1'b0;
      if (S_AXI_ARVALID_I && !S_AXI_RVALID_O && !S_AXI_ARREADY_O) begin
        S_AXI_ARREADY_O <= 1'b1;
        S_AXI_RVALID_O  <= 1'b1;
        S_AXI_RDATA_O   <= rd_mux;
        S_AXI_RRESP_O   <= (S_AXI_ARADDR_I[5:2] <= `FPA_ADDR_IRQ_MASK)
                           ? `FPA_RESP_OKAY : `FPA_RESP_SLVERR;
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### tb/fpa_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "fpa_regs.svh"
// ====================
// bus handshake checker
module fpa_core_sva (
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        RESET_N_I,
  // bus
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic [1:0]  S_AXI_BRESP_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_BREADY_I,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0]  S_AXI_RRESP_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        S_AXI_RREADY_I,
  // interrupt
  input wire logic        IRQ_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  aw_taken_a: assert property (S_AXI_AWVALID_I |-> ##[0:15] S_AXI_AWREADY_O)
    else $error("write address not taken");
  w_taken_a: assert property (S_AXI_WVALID_I |-> ##[0:15] S_AXI_WREADY_O)
    else $error("write data not taken");
  ar_answer_a: assert property (S_AXI_ARVALID_I && !S_AXI_RVALID_O && !S_AXI_ARREADY_O
    |=> S_AXI_ARREADY_O && S_AXI_RVALID_O) else $error("read not answered");
  ar_pulse_a: assert property (S_AXI_ARREADY_O |=> !S_AXI_ARREADY_O)
    else $error("read ready too long");
  r_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O
    && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O)) else $error("read data moved");
  r_done_a: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
    else $error("read valid stuck");
  b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O
    && $stable(S_AXI_BRESP_O)) else $error("write response moved");
  err_zero_a: assert property (S_AXI_RVALID_O && S_AXI_RRESP_O == `FPA_RESP_SLVERR
    |-> S_AXI_RDATA_O == 32'h0) else $error("error read with data");
  read_c: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
  write_c: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
  irq_c: cover property ($rose(IRQ_O));
endmodule
bind fpa_core fpa_core_sva fpa_core_sva_inst (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I), .IRQ_O(IRQ_O)
);
`default_nettype wire

// ### tb/fpa_axi_master.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// bus master in the processor's place
module fpa_axi_master (
  // clock
  input  wire logic        clk_i,
  // write
  output logic [5:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  // read
  output logic [5:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // released lines show the inverse, so a stale value never passes
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    output logic [1:0] r, output bit ok);
    bit aw = 1'b1, w = 1'b1, b = 1'b1;
    int n = 0;
    @(posedge clk_i);
    {awaddr_o, wdata_o, wstrb_o} <= {a, d, 4'hf};
    {awvalid_o, wvalid_o, bready_o} <= 3'b111;
    while ((aw || w || b) && n < 64) begin
      @(posedge clk_i);
      n++;
      if (aw && awready_i) begin
        aw = 1'b0;
        {awvalid_o, awaddr_o} <= {1'b0, ~a};
      end
      if (w && wready_i) begin
        w = 1'b0;
        {wvalid_o, wdata_o} <= {1'b0, ~d};
      end
      if (b && bvalid_i) begin
        b = 1'b0;
        r = bresp_i;
        bready_o <= 1'b0;
      end
      #1;
    end
    ok = !(aw || w || b);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    output logic [1:0] r, output bit ok);
    bit ar = 1'b1, rr = 1'b1;
    int n = 0;
    @(posedge clk_i);
    {araddr_o, arvalid_o, rready_o} <= {a, 2'b11};
    while ((ar || rr) && n < 64) begin
      @(posedge clk_i);
      n++;
      if (ar && arready_i) begin
        ar = 1'b0;
        {arvalid_o, araddr_o} <= {1'b0, ~a};
      end
      if (rr && rvalid_i) begin
        rr = 1'b0;
        d  = rdata_i;
        r  = rresp_i;
        rready_o <= 1'b0;
      end
      #1;
    end
    ok = !(ar || rr);
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "fpa_regs.svh"
module tb;
  // ====================
  // wiring and vectors
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [11:0] c;
    logic [5:0]  a;
    logic [31:0] e;
    logic [31:0] m;
  } fpa_vec_t;
  logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          miscompares = 0;
  int          n_checks = 0;
  fpa_vec_t    vec [22] = '{
    '{16'h7fff,16'h0001,12'h000,6'h10,32'ha,32'hf},
    '{16'h7fff,16'h8000,12'h000,6'h10,32'h2,32'hf},
    '{16'hffff,16'h0001,12'h000,6'h10,32'h5,32'hf},
    '{16'h0001,16'h0001,12'h001,6'h0c,32'h3,32'hffff},
    '{16'h0005,16'h0002,12'h003,6'h0c,32'h2,32'hffff},
    '{16'h8000,16'h0001,12'h002,6'h10,32'h8,32'hb},
    '{16'h8000,16'h0000,12'h009,6'h10,32'ha,32'hb},
    '{16'hf0f0,16'hff00,12'h006,6'h0c,32'h0ff0,32'hffff},
    '{16'hf0f0,16'hff00,12'h004,6'h0c,32'hf000,32'hffff},
    '{16'hf0f0,16'hff00,12'h005,6'h0c,32'hfff0,32'hffff},
    '{16'hf0f0,16'h0000,12'h007,6'h0c,32'h0f0f,32'hffff},
    '{16'hf0f0,16'h0000,12'h008,6'h0c,32'hf0f0,32'hffff},
    '{16'h8000,16'h4000,12'h000,6'h14,32'hc0000000,32'hffffffff},
    '{16'h8000,16'h4000,12'h000,6'h18,32'hff,32'hff},
    '{16'hffff,16'h0002,12'h010,6'h14,32'h0003fffc,32'hffffffff},
    '{16'hffff,16'h0002,12'h020,6'h14,32'hfffffffc,32'hffffffff},
    '{16'h4000,16'h4000,12'h030,6'h14,32'h20008000,32'hffffffff},
    '{16'h0001,16'h0000,12'hf00,6'h1c,32'h8000,32'hffff},
    '{16'h8000,16'h0000,12'h440,6'h1c,32'h0800,32'hffff},
    '{16'h8000,16'h0000,12'h480,6'h1c,32'hf800,32'hffff},
    '{16'h0001,16'h0000,12'h0c0,6'h1c,32'h000e,32'hffff},
    '{16'h4001,16'h0000,12'h0c0,6'h1c,32'h0000,32'hffff}};
  fpa_core fpa_core_inst (.CLK_I(clk), .RESET_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .IRQ_O(irq));
  fpa_axi_master fpa_axi_master_inst (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // a stuck handshake ends the run at once
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    logic [1:0] r;
    bit         ok;
    fpa_axi_master_inst.wr(a, v, r, ok);
    if (!ok) begin
      chk("write handshake", 32'h1, 32'h0);
      close_out();
    end
    chk("bresp", 32'(`FPA_RESP_OKAY), 32'(r));
  endtask
  task automatic rd(input logic [5:0] a, input logic [1:0] er, output logic [31:0] v);
    logic [1:0] r;
    bit         ok;
    fpa_axi_master_inst.rd(a, v, r, ok);
    if (!ok) begin
      chk("read handshake", 32'h1, 32'h0);
      close_out();
    end
    chk("rresp", 32'(er), 32'(r));
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(6'h24, `FPA_RESP_OKAY, d);
    chk("mask", 32'h0, d);
    chk("irq", 32'h0, 32'(irq));
    rd(6'h28, `FPA_RESP_SLVERR, d);
    chk("unmapped", 32'h0, d);
    $display("reset test done");
    foreach (vec[i]) begin
      wr(6'h00, {16'h0000, vec[i].x});
      wr(6'h04, {16'h0000, vec[i].y});
      wr(6'h08, {20'h00000, vec[i].c});
      repeat (2) @(posedge clk);
      rd(vec[i].a, `FPA_RESP_OKAY, d);
      chk($sformatf("vec%0d", i), vec[i].e, d & vec[i].m);
    end
    $display("vector test done");
    wr(6'h24, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, 32'(irq));
    wr(6'h24, 32'hf);
    repeat (2) @(posedge clk);
    chk("irq on", 32'h1, 32'(irq));
    wr(6'h20, 32'hf);
    repeat (2) @(posedge clk);
    rd(6'h20, `FPA_RESP_OKAY, d);
    chk("irq stat", 32'h0, d);
    chk("irq off", 32'h0, 32'(irq));
    $display("interrupt test done");
    close_out();
  end
endmodule
`default_nettype wire
